// >>> sim/emt_checker.sv
// Port assertions for the strobe timer
`include "emt_map.svh"
`timescale 1ns/1ns
`default_nettype none

module emt_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Watched ports
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic moveBusy,
	input wire logic moveDone,
	input wire logic [`EMT_DATA_W-1:0] memAdOut,
	input wire logic memAdOe,
	input wire logic memLatch,
	input wire logic memRdN,
	input wire logic memWrN
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	chk_apb_zero_wait: assert property (pready == (psel && penable))
		else $error("pready wrong");
	chk_done_after_busy: assert property (moveDone |-> !moveBusy && $past(moveBusy))
		else $error("done misplaced");
	chk_done_one_cycle: assert property (moveDone |=> !moveDone)
		else $error("done too long");
	chk_min_length: assert property ($rose(moveBusy) |-> moveBusy[*5])
		else $error("transfer too short");
	chk_tail_cycles: assert property ($rose(memRdN) || $rose(memWrN) |-> moveBusy[*3])
		else $error("tail too short");
	chk_strobe_alone: assert property (!memRdN || !memWrN |-> moveBusy && !memLatch && (memRdN || memWrN))
		else $error("strobe overlap");
	chk_latch_drive: assert property (memLatch |-> moveBusy && memAdOe)
		else $error("latch undriven");
	chk_latch_low_gap: assert property ($fell(memLatch) |-> memRdN && memWrN)
		else $error("no latch low phase");
	chk_wdata_steady: assert property (!memWrN && $past(!memWrN) |-> memAdOe && $stable(memAdOut))
		else $error("write data moved");
	cover property (moveDone);
	cover property (memLatch);
	cover property (!memWrN);
endmodule // emt_checker

bind emt_top emt_checker u_chk (.clk, .reset_n, .psel, .penable, .pready, .moveBusy, .moveDone,
	.memAdOut, .memAdOe, .memLatch, .memRdN, .memWrN);

`default_nettype wire

// >>> sim/emt_mem_model.sv
// Behavioural asynchronous byte memory on the timer's pins
`timescale 1ns/1ns
`default_nettype none

module emt_mem_model (
	// Pins from the timer
	input wire logic clk,
	input wire logic [15:0] memAddr,
	input wire logic [7:0] memAdOut,
	input wire logic memLatch,
	input wire logic memRdN,
	input wire logic memWrN,
	// Access time in cycles
	input wire logic [3:0] slowCyc,
	// Bus back to the timer
	output logic [7:0] memAdIn
);
	logic [7:0] mem [256];
	logic [7:0] lo, junk;
	logic [3:0] rdCnt;
	logic muxed, stbPrev;
	wire logic [7:0] idx = muxed ? lo : memAddr[7:0];
	initial
	begin
		foreach (mem[i])
			mem[i] = 8'(i) ^ 8'h5A;
		{muxed, stbPrev, rdCnt, lo, junk} = 15'h3C;
	end
	// Released bus toggles so stale data never looks valid
	assign memAdIn = (!memRdN && rdCnt >= slowCyc) ? mem[idx] : junk;
	always @(posedge clk)
	begin
		junk <= ~junk;
		rdCnt <= memRdN ? 4'h0 : rdCnt + 4'h1;
		stbPrev <= !(memRdN && memWrN);
		if (memLatch)
			lo <= memAdOut;
		muxed <= memLatch || (muxed && !(stbPrev && memRdN && memWrN));
		if (!memWrN)
			mem[idx] <= memAdOut;
	end
endmodule // emt_mem_model

`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the external memory strobe timer
`include "emt_map.svh"
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	import emt_pkg::*;
	logic clk, reset_n, psel, penable, pwrite, moveReq, e;
	logic pready, pslverr, moveBusy, moveDone, memAdOe, memLatch, memRdN, memWrN;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, n;
	logic [3:0] pstrb, slowCyc;
	logic [7:0] moveRdata, memAdOut, memAdIn, rd;
	logic [15:0] memAddr;
	emt_req_t moveCmd;
	int err_count, num_checks;
	emt_timing_t tv[5] = '{8'h00, 8'h00, 8'h00, 8'h95, 8'h0C};
	emt_config_t cv[5] = '{5'h00, 5'h10, 5'h1F, 5'h00, 5'h16};
	logic [3:0] sv[5] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h3};

	emt_top DUT (.clk, .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .moveReq, .moveCmd, .moveBusy, .moveDone, .moveRdata, .memAddr,
		.memAdOut, .memAdOe, .memAdIn, .memLatch, .memRdN, .memWrN);
	emt_mem_model u_mem (.clk, .memAddr, .memAdOut, .memLatch, .memRdN, .memWrN, .slowCyc, .memAdIn);

	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic hang();
		err_count++;
		$display("[FAIL] %0t wait ran out", $time);
		stop_test();
	endtask
	// Each access starts one edge on, so psel never toggles twice in a step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int k = 0;
		@(posedge clk);
		{psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			if (++k > 50)
				hang();
		end
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task automatic move(input logic w, input logic [15:0] a, input logic [7:0] d);
		int k = 0;
		@(posedge clk);
		moveCmd <= '{w, a, d};
		moveReq <= 1'b1;
		@(posedge clk);
		moveReq <= 1'b0;
		n = 32'h0;
		do
		begin
			@(posedge clk);
			n += (moveBusy === 1'b1);
			if (++k > 100)
				hang();
		end
		while (moveDone !== 1'b1);
		rd = moveRdata;
	endtask
	function automatic logic [31:0] expLen(emt_timing_t t, emt_config_t c);
		return 32'h5 + t.setup + t.width + t.hold + (c.muxMode ? c.latchHigh + c.latchLow + 32'h2 : 32'h0);
	endfunction

	initial
	begin
		clk = 1'b0;
		forever
			#4 clk = ~clk;
	end
	initial
	begin
		reset_n = 1'b0;
		{psel, penable, pwrite, moveReq, paddr, pwdata, pstrb, moveCmd, slowCyc} = '0;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		apb(1'b0, `EMT_OFF_CONFIG, 32'h0, 4'hF);
		check(q, 32'h0F);
		apb(1'b1, `EMT_OFF_TIMING, 32'h0, 4'h0);
		apb(1'b0, `EMT_OFF_TIMING, 32'h0, 4'hF);
		check(q, 32'hFF);
		apb(1'b0, 12'h010, 32'h0, 4'hF);
		check({q[30:0], e}, 32'h1);
		move(1'b0, 16'h0042, 8'h00);
		check(n, 32'h1A);
		check(rd, 8'h42 ^ 8'h5A);
		apb(1'b0, `EMT_OFF_STATUS, 32'h0, 4'hF);
		check(q, {16'h0000, 8'h42 ^ 8'h5A, 8'h00});
		for (int i = 0; i < 5; i++)
		begin
			slowCyc <= sv[i];
			apb(1'b1, `EMT_OFF_TIMING, 32'(tv[i]), 4'hF);
			apb(1'b1, `EMT_OFF_CONFIG, 32'(cv[i]), 4'hF);
			apb(1'b0, `EMT_OFF_TIMING, 32'h0, 4'hF);
			check(q, 32'(tv[i]));
			move(1'b1, {8'h12 + 8'(i), 8'h30 + 8'(i)}, 8'hA0 + 8'(i));
			check(n, expLen(tv[i], cv[i]));
			move(1'b0, {8'h12 + 8'(i), 8'h30 + 8'(i)}, 8'h00);
			check(rd, 8'hA0 + 8'(i));
			apb(1'b0, `EMT_OFF_LENGTH, 32'h0, 4'hF);
			check(q, expLen(tv[i], cv[i]));
		end
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		apb(1'b0, `EMT_OFF_TIMING, 32'h0, 4'hF);
		check(q, 32'hFF);
		apb(1'b0, `EMT_OFF_CONFIG, 32'h0, 4'hF);
		check(q, 32'h0F);
		stop_test();
	end
endmodule // tb_top

`default_nettype wire

// >>> src/emt_map.svh
// Register offsets, field layout, reset values and cycle counts of the strobe timer
`ifndef EMT_MAP_SVH
`define EMT_MAP_SVH

`define EMT_APB_AW 12
`define EMT_OFF_TIMING 12'h000
`define EMT_OFF_CONFIG 12'h004
`define EMT_OFF_STATUS 12'h008
`define EMT_OFF_LENGTH 12'h00C

`define EMT_TIMING_W 8
`define EMT_CONFIG_W 5
`define EMT_TIMING_RESET 8'hFF
`define EMT_CONFIG_RESET 5'h0F

`define EMT_STAT_BUSY_BIT 0
`define EMT_STAT_PHASE_LSB 1
`define EMT_STAT_RDATA_LSB 8

`define EMT_ADDR_W 16
`define EMT_DATA_W 8
`define EMT_CNT_W 5
`define EMT_LEN_W 8

`define EMT_LAUNCH_CYC 5'h01
`define EMT_TAIL_CYC 5'h03
`define EMT_SYNC_STAGES 3

`endif

// >>> src/emt_phase_cnt.sv
// Down-counter that times one phase of an external transfer
`timescale 1ns/1ns
`default_nettype none

module emt_phase_cnt #(
	parameter int W = 5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Load and status
	input wire logic load,
	input wire logic [W-1:0] loadVal,
	output logic atZero
);

	logic [W-1:0] count;

	if (W < 5)
	begin : g_bad_width
		$error("emt_phase_cnt needs at least 5 bits for a 16-cycle strobe");
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			count <= '0;
		else if (load)
			count <= loadVal;
		else if (count != '0)
			count <= count - W'(1);
	end

	assign atZero = (count == '0);

endmodule // emt_phase_cnt

`default_nettype wire

// >>> src/emt_pkg.sv
// Types shared by the external memory strobe timer
package emt_pkg;

	typedef struct packed {
		logic [1:0] setup;
		logic [3:0] width;
		logic [1:0] hold;
	} emt_timing_t;

	typedef struct packed {
		logic muxMode;
		logic [1:0] latchLow;
		logic [1:0] latchHigh;
	} emt_config_t;

	typedef struct packed {
		logic write;
		logic [15:0] addr;
		logic [7:0] wdata;
	} emt_req_t;

	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_LAUNCH = 3'b001,
		PH_LATCH_HI = 3'b010,
		PH_LATCH_LO = 3'b011,
		PH_SETUP = 3'b100,
		PH_STROBE = 3'b101,
		PH_HOLD = 3'b110,
		PH_TAIL = 3'b111
	} emt_phase_t;

endpackage

// >>> src/emt_top.sv
// External memory strobe timer: APB registers, phase sequencer and memory pins
`include "emt_map.svh"
`timescale 1ns/1ns
`default_nettype none

module emt_top (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// APB slave
	input wire logic [`EMT_APB_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core off-chip move request
	input wire logic moveReq,
	input wire emt_pkg::emt_req_t moveCmd,
	output logic moveBusy,
	output logic moveDone,
	output logic [`EMT_DATA_W-1:0] moveRdata,
	// External memory pins
	output logic [`EMT_ADDR_W-1:0] memAddr,
	output logic [`EMT_DATA_W-1:0] memAdOut,
	output logic memAdOe,
	input wire logic [`EMT_DATA_W-1:0] memAdIn,
	output logic memLatch,
	output logic memRdN,
	output logic memWrN
);
	import emt_pkg::*;

	emt_timing_t timingCtrl;
	emt_config_t configCtrl;
	emt_timing_t xferTiming;
	emt_config_t xferConfig;
	emt_req_t xferCmd;
	emt_phase_t phase;
	emt_phase_t next_phase;
	logic [`EMT_CNT_W-1:0] next_len;
	logic phaseDone;
	logic cntLoad;
	logic accept;
	logic apbWrite;
	logic apbSetup;
	logic addrKnown;
	logic [31:0] readValue;
	logic [`EMT_LEN_W-1:0] cycleCount;
	logic [`EMT_LEN_W-1:0] lastLength;
	logic [`EMT_DATA_W-1:0] padSync1;
	logic [`EMT_DATA_W-1:0] padSync2;
	logic [`EMT_DATA_W-1:0] padSync3;
	logic [2:0] sampleMark;

	// APB: registered read data, so one setup and one access cycle
	assign apbSetup = psel & ~penable;
	assign pready = psel & penable;
	assign apbWrite = psel & penable & pwrite & pstrb[0];

	always_comb
	begin
		addrKnown = 1'b1;
		case (paddr)
			`EMT_OFF_TIMING: readValue = {24'h000000, timingCtrl};
			`EMT_OFF_CONFIG: readValue = {27'h0000000, configCtrl};
			`EMT_OFF_STATUS:
			begin
				readValue = 32'h00000000;
				readValue[`EMT_STAT_BUSY_BIT] = moveBusy;
				readValue[`EMT_STAT_PHASE_LSB +: 3] = phase;
				readValue[`EMT_STAT_RDATA_LSB +: `EMT_DATA_W] = moveRdata;
			end
			`EMT_OFF_LENGTH: readValue = {24'h000000, lastLength};
			default:
			begin
				readValue = 32'h00000000;
				addrKnown = 1'b0;
			end
		endcase
	end

	assign pslverr = pready & ~addrKnown;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			prdata <= 32'h00000000;
		else if (apbSetup)
			prdata <= pwrite ? 32'h00000000 : readValue;
	end

	// Reset leaves the slowest timing in place for unknown parts
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			timingCtrl <= `EMT_TIMING_RESET;
		else if (apbWrite && paddr == `EMT_OFF_TIMING)
			timingCtrl <= pwdata[`EMT_TIMING_W-1:0];
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			configCtrl <= `EMT_CONFIG_RESET;
		else if (apbWrite && paddr == `EMT_OFF_CONFIG)
			configCtrl <= pwdata[`EMT_CONFIG_W-1:0];
	end

	// Settings are frozen per transfer so a mid-transfer write cannot tear it
	assign accept = (phase == PH_IDLE) & moveReq;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			xferTiming <= `EMT_TIMING_RESET;
			xferConfig <= `EMT_CONFIG_RESET;
			xferCmd <= '0;
		end
		else if (accept)
		begin
			xferTiming <= timingCtrl;
			xferConfig <= configCtrl;
			xferCmd <= moveCmd;
		end
	end

	// Phase sequencer
	emt_phase_cnt #(
		.W(`EMT_CNT_W)
	) u_phase_cnt (
		.clk(clk),
		.reset_n(reset_n),
		.load(cntLoad),
		.loadVal(next_len - `EMT_CNT_W'(1)),
		.atZero(phaseDone)
	);

	always_comb
	begin
		next_phase = phase;
		cntLoad = 1'b0;
		case (phase)
			PH_IDLE:
				if (moveReq)
					next_phase = PH_LAUNCH;
			PH_LAUNCH:
				if (phaseDone)
				begin
					if (xferConfig.muxMode)
						next_phase = PH_LATCH_HI;
					else if (xferTiming.setup != 2'b00)
						next_phase = PH_SETUP;
					else
						next_phase = PH_STROBE;
				end
			PH_LATCH_HI:
				if (phaseDone)
					next_phase = PH_LATCH_LO;
			PH_LATCH_LO:
				if (phaseDone)
					next_phase = (xferTiming.setup != 2'b00) ? PH_SETUP : PH_STROBE;
			PH_SETUP:
				if (phaseDone)
					next_phase = PH_STROBE;
			PH_STROBE:
				if (phaseDone)
					next_phase = (xferTiming.hold != 2'b00) ? PH_HOLD : PH_TAIL;
			PH_HOLD:
				if (phaseDone)
					next_phase = PH_TAIL;
			PH_TAIL:
				if (phaseDone)
					next_phase = PH_IDLE;
			default:
				next_phase = PH_IDLE;
		endcase
		if (next_phase != phase)
			cntLoad = 1'b1;
	end

	// Launch and tail lengths are fixed; every other phase takes its length from the frozen copy
	always_comb
	begin
		case (next_phase)
			PH_LAUNCH: next_len = `EMT_LAUNCH_CYC;
			PH_LATCH_HI: next_len = {3'b000, xferConfig.latchHigh} + 5'h01;
			PH_LATCH_LO: next_len = {3'b000, xferConfig.latchLow} + 5'h01;
			PH_SETUP: next_len = {3'b000, xferTiming.setup};
			PH_STROBE: next_len = {1'b0, xferTiming.width} + 5'h01;
			PH_HOLD: next_len = {3'b000, xferTiming.hold};
			PH_TAIL: next_len = `EMT_TAIL_CYC;
			default: next_len = 5'h01;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			phase <= PH_IDLE;
		else
			phase <= next_phase;
	end

	assign moveBusy = (phase != PH_IDLE);

	// Transfer length in cycles, kept for software
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			cycleCount <= '0;
		else if (accept)
			cycleCount <= '0;
		else if (moveBusy)
			cycleCount <= cycleCount + `EMT_LEN_W'(1);
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			lastLength <= '0;
		else if (phase == PH_TAIL && phaseDone)
			lastLength <= cycleCount + `EMT_LEN_W'(1);
	end

	// Pin side outputs, all registered from the next phase
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			memAddr <= '0;
			memLatch <= 1'b0;
			memRdN <= 1'b1;
			memWrN <= 1'b1;
		end
		else
		begin
			if (next_phase == PH_LAUNCH)
				memAddr <= configCtrl.muxMode ? {moveCmd.addr[15:8], 8'h00} : moveCmd.addr;
			memLatch <= (next_phase == PH_LATCH_HI);
			memRdN <= ~(next_phase == PH_STROBE && !xferCmd.write);
			memWrN <= ~(next_phase == PH_STROBE && xferCmd.write);
		end
	end

	// Shared bus: address byte in latch phases, write data from setup to hold end
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			memAdOut <= '0;
			memAdOe <= 1'b0;
		end
		else
		begin
			case (next_phase)
				PH_LATCH_HI, PH_LATCH_LO:
				begin
					memAdOut <= xferCmd.addr[7:0];
					memAdOe <= 1'b1;
				end
				PH_SETUP, PH_STROBE:
				begin
					memAdOut <= xferCmd.wdata;
					memAdOe <= xferCmd.write;
				end
				PH_HOLD:
				begin
					memAdOut <= xferCmd.wdata;
					memAdOe <= xferCmd.write;
				end
				default:
				begin
					memAdOut <= memAdOut;
					memAdOe <= 1'b0;
				end
			endcase
		end
	end

	// Bus input synchroniser, three stages deep
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			padSync1 <= '0;
			padSync2 <= '0;
			padSync3 <= '0;
		end
		else
		begin
			padSync1 <= memAdIn;
			padSync2 <= padSync1;
			padSync3 <= padSync2;
		end
	end

	// A one-cycle strobe leaves the byte valid at one edge only, so it is
	// taken from stage three at a fixed edge; waiting for agreement would miss it

	// Marks the strobe's last edge; the tail covers the sync delay
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			sampleMark <= 3'b000;
		else
			sampleMark <= {sampleMark[1:0], phase == PH_STROBE && phaseDone && !xferCmd.write};
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			moveRdata <= '0;
		else if (sampleMark[2])
			moveRdata <= padSync3;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			moveDone <= 1'b0;
		else
			moveDone <= (phase == PH_TAIL) && phaseDone;
	end

endmodule // emt_top

`default_nettype wire
